/* include/ccp_pkg.sv */
// Package: constants and types for the codec control port decoder
package ccp_pkg;

    // ****************************************************************
    // Link framing
    // ****************************************************************
    localparam int unsigned BITS_PER_BYTE = 8;
    localparam logic [3:0]  BIT_COUNT_FULL = 4'h8;
    localparam logic [3:0]  BIT_COUNT_ONE  = 4'h1;
    localparam logic [3:0]  BIT_COUNT_ZERO = 4'h0;

    // ****************************************************************
    // Address byte layout
    // ****************************************************************
    localparam int unsigned ADDR_MSB = 7;
    localparam int unsigned ADDR_LSB = 2;
    localparam int unsigned TYPE_MSB = 1;
    localparam int unsigned TYPE_LSB = 0;
    localparam logic [1:0]  TYPE_DATA   = 2'h0;
    localparam logic [1:0]  TYPE_STATUS = 2'h2;

    // ****************************************************************
    // Data byte layout
    // ****************************************************************
    localparam int unsigned SEL_MSB   = 7;
    localparam int unsigned SEL_LSB   = 6;
    localparam int unsigned VALUE_MSB = 5;
    localparam logic [1:0]  SEL_VOLUME     = 2'h0;
    localparam logic [1:0]  SEL_BASS_TREB  = 2'h1;
    localparam logic [1:0]  SEL_EMPH_MUTE  = 2'h2;
    localparam logic [1:0]  SEL_POWER      = 2'h3;
    localparam logic [1:0]  SEL_SETUP      = 2'h0;
    localparam int unsigned EMPH_GUARD_BIT = 5;

    // ****************************************************************
    // Register reset values
    // ****************************************************************
    localparam logic [5:0] SETUP_RESET     = 6'h00;
    localparam logic [5:0] VOLUME_RESET    = 6'h00;
    localparam logic [5:0] BASS_TREB_RESET = 6'h00;
    localparam logic [5:0] EMPH_MUTE_RESET = 6'h00;
    localparam logic [1:0] POWER_RESET     = 2'h0;

    // ****************************************************************
    // Decode constants
    // ****************************************************************
    localparam logic [5:0] VOLUME_MAX_STEP = 6'h3D;
    localparam logic [5:0] VOLUME_UNITY    = 6'h01;
    localparam logic [4:0] BASS_MIN_LIMIT  = 5'h12;
    localparam logic [4:0] BASS_MAX_LIMIT  = 5'h18;
    localparam logic [1:0] TONE_FLAT       = 2'h0;
    localparam logic [1:0] TONE_MIN        = 2'h1;
    localparam logic [1:0] TONE_MAX        = 2'h3;

    typedef enum logic [3:0] {
        SESSION_DESELECTED = 4'h1,
        SESSION_DATA       = 4'h2,
        SESSION_STATUS     = 4'h4,
        SESSION_UNUSED     = 4'h8
    } ccp_session_type;

endpackage : ccp_pkg

/* tb/ccp_control_port_tb.sv */
// Self-checking testbench of the control port decoder
`timescale 1ns/1ps
module ccp_control_port_tb;
    import ccp_pkg::*;
    localparam logic [5:0] OWN_ADDR     = 6'h2C; // arbitrary value
    localparam logic [5:0] FOREIGN_ADDR = 6'h13; // arbitrary value
    localparam logic [41:0] VOL_CODES   = {6'h00, 6'h01, 6'h02, 6'h1F, 6'h3D, 6'h3E, 6'h3F};
    logic       clock, reset, lclk, lsel, ldat;
    logic [1:0] ratio, treble, emph, tmode, power, tmode_eff;
    logic [2:0] fmt, treble_db;
    logic [3:0] bass;
    logic [4:0] bass_db;
    logic [5:0] volume, att_db, vcode;
    logic       dc_en, mute, selected, full_att, dac_on, adc_on;
    logic [7:0] e_bass, e_treb, e_eff;
    int         fail_count;
    int         compares;

    ccp_host_model u_ccp_host_model (.ctl_shift_clock(lclk), .ctl_select_line(lsel), .ctl_serial_data(ldat));
    ccp_control_port #(.DEVICE_ADDRESS(OWN_ADDR)) u_ccp_control_port (
        .clock(clock), .reset(reset), .ctl_shift_clock(lclk), .ctl_select_line(lsel),
        .ctl_serial_data(ldat), .master_clock_ratio(ratio), .audio_format(fmt),
        .offset_removal_en(dc_en), .playback_attenuation(volume), .bass_level(bass),
        .high_shelf_level(treble), .emphasis_curve_sel(emph), .silence_en(mute),
        .tone_mode(tmode), .converter_power_sel(power), .iface_selected(selected),
        .attenuation_db(att_db), .full_attenuation(full_att), .bass_gain_db(bass_db),
        .treble_gain_db(treble_db), .tone_mode_eff(tmode_eff), .dac_power_on(dac_on),
        .adc_power_on(adc_on));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ********
    // Shared tasks
    // ********
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Core needs about four cycles after the eighth link edge
    task automatic settle();
        repeat (8) @(posedge clock);
        #5;
    endtask : settle

    task automatic addr(input logic [5:0] dev, input logic [1:0] kind);
        u_ccp_host_model.send_byte(1'b0, {dev, kind});
        settle();
    endtask : addr

    task automatic data(input logic [1:0] sel, input logic [5:0] val);
        u_ccp_host_model.send_byte(1'b1, {sel, val});
        settle();
    endtask : data

    task automatic complete_run();
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic do_reset();
        reset = 1'b1;
        repeat (10) @(posedge clock);
        #5 reset = 1'b0;
        settle();
        check("setup", 8'h00, 8'({ratio, fmt, dc_en}));
        check("volume", 8'h00, {selected, full_att, volume});
        check("tone", 8'h00, {bass, treble, tmode});
        check("power", 8'h00, 8'({emph, mute, power, dac_on, adc_on}));
        check("decoded", 8'h00, {att_db, tmode_eff});
        check("gains", 8'h00, {bass_db, treble_db});
    endtask : do_reset

    initial begin
        #(5000 * 100);
        fail_count++;
        complete_run();
    end

    // ********
    // Test sequence
    // ********
    initial begin
        fail_count = 0;
        compares = 0;
        do_reset();
        addr(OWN_ADDR, TYPE_DATA);
        check("iface_selected", 8'h01, 8'(selected));
        for (int i = 0; i < 7; i++) begin
            vcode = VOL_CODES[6*i +: 6];
            data(SEL_VOLUME, vcode);
            check("full_attenuation", 8'(vcode > VOLUME_MAX_STEP), 8'(full_att));
            check("attenuation_db", 8'(vcode < 6'h02 ? 6'h00 : vcode > VOLUME_MAX_STEP ? 6'h3C : vcode - 6'h01),
                  8'(att_db));
        end
        for (int c = 0; c < 64; c += 7) begin
            data(SEL_VOLUME, 6'(c));
            check("playback_attenuation", 8'(c), 8'(volume));
            check("full_attenuation", 8'(c >= 62), 8'(full_att));
            if (c < 62) check("attenuation_db", 8'(c < 2 ? 0 : c - 1), 8'(att_db));
        end
        data(SEL_VOLUME, 6'h01);
        check("attenuation_db", 8'h00, 8'(att_db));
        data(SEL_VOLUME, 6'h3D);
        check("attenuation_db", 8'h3C, 8'(att_db));
        data(SEL_BASS_TREB, {4'hB, 2'h2});
        check("bass_treble", 8'({4'hB, 2'h2}), 8'({bass, treble}));
        for (int m = 0; m < 4; m++) begin
            data(SEL_EMPH_MUTE, {1'b0, 2'(m), m[0], 2'(m)});
            e_eff = (m == 0) ? 8'h00 : (m == 3) ? 8'h03 : 8'h01;
            e_bass = (m == 0) ? 8'h00 : (m == 3) ? 8'h16 : 8'h12;
            e_treb = (m == 0) ? 8'h00 : 8'h04;
            check("emphasis_curve_sel", 8'(m), 8'(emph));
            check("silence_en", 8'(m[0]), 8'(mute));
            check("tone_mode", 8'(m), 8'(tmode));
            check("tone_mode_eff", e_eff, 8'(tmode_eff));
            check("bass_gain_db", e_bass, 8'(bass_db));
            check("treble_gain_db", e_treb, 8'(treble_db));
        end
        data(SEL_BASS_TREB, {4'hF, 2'h3});
        check("bass_gain_db", 8'h18, 8'(bass_db));
        check("treble_gain_db", 8'h06, 8'(treble_db));
        data(SEL_EMPH_MUTE, 6'h20);
        check("tone_mode", 8'h03, 8'(tmode));
        for (int p = 0; p < 4; p++) begin
            data(SEL_POWER, {4'h0, 2'(p)});
            check("converter_power_sel", 8'(p), 8'(power));
            check("power_on", {6'h00, p[1], p[0]}, {6'h00, adc_on, dac_on});
        end
        addr(OWN_ADDR, TYPE_STATUS);
        for (int s = 0; s < 8; s++) begin
            data(SEL_SETUP, {2'(s % 3), 3'(s), s[0]});
            check("master_clock_ratio", 8'(s % 3), 8'(ratio));
            check("audio_format", 8'(s), 8'(fmt));
            check("offset_removal_en", 8'(s[0]), 8'(dc_en));
        end
        data(2'h1, 6'h15);
        check("bass_treble", 8'h3F, 8'({bass, treble}));
        check("setup", {2'h0, 2'h1, 3'h7, 1'b1}, {2'h0, ratio, fmt, dc_en});
        check("playback_attenuation", 8'h3D, 8'(volume));
        addr(FOREIGN_ADDR, TYPE_DATA);
        check("iface_selected", 8'h00, 8'(selected));
        data(SEL_VOLUME, 6'h05);
        check("playback_attenuation", 8'h3D, 8'(volume));
        for (int k = 1; k < 4; k += 2) begin
            addr(OWN_ADDR, 2'(k));
            check("iface_selected", 8'h00, 8'(selected));
            data(SEL_VOLUME, 6'h07);
            check("playback_attenuation", 8'h3D, 8'(volume));
        end
        addr(OWN_ADDR, TYPE_DATA);
        data(SEL_VOLUME, 6'h09);
        data(SEL_POWER, 6'h01);
        check("playback_attenuation", 8'h09, 8'(volume));
        check("converter_power_sel", 8'h01, 8'(power));
        do_reset();
        complete_run();
    end
endmodule : ccp_control_port_tb

/* tb/ccp_host_model.sv */
// Host controller model driving the three-wire control link
`timescale 1ns/1ps
module ccp_host_model
    import ccp_pkg::*;
#(
    parameter int HALF_NS = 32 // half of the 64 ns link clock
) (
    output logic ctl_shift_clock, // link clock, still between frames
    output logic ctl_select_line, // low address, high data
    output logic ctl_serial_data  // serial data, lsb first
);
    initial begin
        ctl_shift_clock = 1'b0;
        ctl_select_line = 1'b1;
        ctl_serial_data = 1'b0;
    end

    // ********
    // Byte transfer
    // ********
    task automatic send_byte(input logic mode, input logic [7:0] value);
        ctl_select_line = mode;
        for (int i = 0; i < BITS_PER_BYTE; i++) begin
            ctl_serial_data = value[i];
            #(HALF_NS) ctl_shift_clock = 1'b1;
            #(HALF_NS) ctl_shift_clock = 1'b0;
        end
        // Inverse after release, so a stale bit never looks valid
        ctl_serial_data = ~value[7];
    endtask : send_byte
endmodule : ccp_host_model

/* verilog/ccp_control_port.sv */
// Module: three-wire write-only control port decoder of the codec
`timescale 1ns/1ps
module ccp_control_port
    import ccp_pkg::*;
#(
    parameter logic [5:0] DEVICE_ADDRESS = 6'h2A // arbitrary value
) (
    input  wire logic       clock,               // core clock, 10 MHz
    input  wire logic       reset,               // async reset, active high
    input  wire logic       ctl_shift_clock,     // link clock from controller
    input  wire logic       ctl_select_line,     // low address, high data
    input  wire logic       ctl_serial_data,     // serial data, lsb first
    output logic [1:0]      master_clock_ratio,  // system clock ratio code
    output logic [2:0]      audio_format,        // audio data format code
    output logic            offset_removal_en,   // DC filter enable
    output logic [5:0]      playback_attenuation,// volume code
    output logic [3:0]      bass_level,          // bass code
    output logic [1:0]      high_shelf_level,    // treble code
    output logic [1:0]      emphasis_curve_sel,  // de-emphasis select
    output logic            silence_en,          // digital mute
    output logic [1:0]      tone_mode,           // raw tone mode code
    output logic [1:0]      converter_power_sel, // power control code
    output logic            iface_selected,      // data or status group open
    output logic [5:0]      attenuation_db,      // attenuation in dB
    output logic            full_attenuation,    // output fully attenuated
    output logic [4:0]      bass_gain_db,        // bass boost in dB
    output logic [2:0]      treble_gain_db,      // treble boost in dB
    output logic [1:0]      tone_mode_eff,       // flat, min or max
    output logic            dac_power_on,        // DAC powered
    output logic            adc_power_on         // ADC powered
);

    // ****************************************************************
    // Link domain: bit counter and shifter
    // ****************************************************************
    logic [3:0] bit_count;
    logic [7:0] shift_reg;
    logic       last_select;
    logic [7:0] hold_byte;
    logic       hold_mode;
    logic       hold_toggle;
    logic [3:0] next_bit_count;
    logic [7:0] next_shift;

    // A change of the mode line restarts framing, so a stopped clock leaves no stale bits when the next byte has the other mode
    always_comb begin
        if ((ctl_select_line != last_select) || (bit_count == BIT_COUNT_FULL)) begin
            next_bit_count = BIT_COUNT_ONE;
        end else begin
            next_bit_count = bit_count + BIT_COUNT_ONE;
        end
        next_shift = {ctl_serial_data, shift_reg[7:1]};
    end

    always_ff @(posedge ctl_shift_clock or posedge reset) begin
        if (reset) begin
            bit_count   <= BIT_COUNT_ZERO;
            shift_reg   <= 8'h00;
            last_select <= 1'b0;
        end else begin
            bit_count   <= next_bit_count;
            shift_reg   <= next_shift;
            last_select <= ctl_select_line;
        end
    end

    // Hand-off: byte stays stable in hold_byte for at least eight link clocks
    always_ff @(posedge ctl_shift_clock or posedge reset) begin
        if (reset) begin
            hold_byte   <= 8'h00;
            hold_mode   <= 1'b0;
            hold_toggle <= 1'b0;
        end else if (next_bit_count == BIT_COUNT_FULL) begin
            hold_byte   <= next_shift;
            hold_mode   <= ctl_select_line;
            hold_toggle <= ~hold_toggle;
        end
    end

    // ****************************************************************
    // Crossing into the core domain
    // ****************************************************************
    logic toggle_sync;
    logic toggle_seen;
    logic byte_event;

    ccp_sync2 #(
        .WIDTH (1)
    ) u_toggle_sync (
        .clock    (clock),
        .reset    (reset),
        .async_in (hold_toggle),
        .sync_out (toggle_sync)
    );

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            toggle_seen <= 1'b0;
        end else begin
            toggle_seen <= toggle_sync;
        end
    end

    assign byte_event = toggle_sync ^ toggle_seen;

    // ****************************************************************
    // Session state
    // ****************************************************************
    ccp_session_type session;
    ccp_session_type next_session;
    logic            addr_match;
    logic [1:0]      xfer_type;
    logic [1:0]      reg_sel;

    assign addr_match = (hold_byte[ADDR_MSB:ADDR_LSB] == DEVICE_ADDRESS);
    assign xfer_type  = hold_byte[TYPE_MSB:TYPE_LSB];
    assign reg_sel    = hold_byte[SEL_MSB:SEL_LSB];

    always_comb begin
        next_session = session;
        if (byte_event && !hold_mode) begin
            if (!addr_match) begin
                next_session = SESSION_DESELECTED;
            end else begin
                case (xfer_type)
                    TYPE_DATA:   next_session = SESSION_DATA;
                    TYPE_STATUS: next_session = SESSION_STATUS;
                    default:     next_session = SESSION_UNUSED;
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            session <= SESSION_DESELECTED;
        end else begin
            session <= next_session;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            iface_selected <= 1'b0;
        end else begin
            iface_selected <= (next_session == SESSION_DATA) || (next_session == SESSION_STATUS);
        end
    end

    // ****************************************************************
    // Setting registers
    // ****************************************************************
    logic data_write;
    logic status_write;

    // Writes land only on a completed data byte inside an open group
    assign data_write   = byte_event && hold_mode && (session == SESSION_DATA);
    assign status_write = byte_event && hold_mode && (session == SESSION_STATUS);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {master_clock_ratio, audio_format, offset_removal_en} <= SETUP_RESET;
        end else if (status_write && (reg_sel == SEL_SETUP)) begin
            master_clock_ratio <= hold_byte[5:4];
            audio_format       <= hold_byte[3:1];
            offset_removal_en  <= hold_byte[0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            playback_attenuation <= VOLUME_RESET;
        end else if (data_write && (reg_sel == SEL_VOLUME)) begin
            playback_attenuation <= hold_byte[VALUE_MSB:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {bass_level, high_shelf_level} <= BASS_TREB_RESET;
        end else if (data_write && (reg_sel == SEL_BASS_TREB)) begin
            bass_level       <= hold_byte[5:2];
            high_shelf_level <= hold_byte[1:0];
        end
    end

    // Bit 5 set is not a defined layout in this group, so such a byte is dropped
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {emphasis_curve_sel, silence_en, tone_mode} <= EMPH_MUTE_RESET[4:0];
        end else if (data_write && (reg_sel == SEL_EMPH_MUTE) && !hold_byte[EMPH_GUARD_BIT]) begin
            emphasis_curve_sel <= hold_byte[4:3];
            silence_en         <= hold_byte[2];
            tone_mode          <= hold_byte[1:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            converter_power_sel <= POWER_RESET;
        end else if (data_write && (reg_sel == SEL_POWER)) begin
            converter_power_sel <= hold_byte[1:0];
        end
    end

    // ****************************************************************
    // Decoded settings, one cycle behind the codes
    // ****************************************************************
    logic [1:0] next_tone_eff;
    logic [5:0] next_atten_db;
    logic [4:0] next_bass_db;
    logic [4:0] bass_raw_db;
    logic [2:0] next_treble_db;

    always_comb begin
        case (tone_mode)
            2'h0:    next_tone_eff = TONE_FLAT;
            2'h3:    next_tone_eff = TONE_MAX;
            default: next_tone_eff = TONE_MIN;
        endcase
    end

    always_comb begin
        if (playback_attenuation <= VOLUME_UNITY) begin
            next_atten_db = 6'h00;
        end else if (playback_attenuation > VOLUME_MAX_STEP) begin
            next_atten_db = VOLUME_MAX_STEP - VOLUME_UNITY;
        end else begin
            next_atten_db = playback_attenuation - VOLUME_UNITY;
        end
    end

    // Saturation is applied on the decoded dB, not the code, to keep one table per mode
    always_comb begin
        bass_raw_db = {bass_level, 1'b0};
        if (next_tone_eff == TONE_FLAT) begin
            next_bass_db   = 5'h00;
            next_treble_db = 3'h0;
        end else begin
            next_treble_db = {high_shelf_level, 1'b0};
            if ((next_tone_eff == TONE_MIN) && (bass_raw_db > BASS_MIN_LIMIT)) begin
                next_bass_db = BASS_MIN_LIMIT;
            end else if (bass_raw_db > BASS_MAX_LIMIT) begin
                next_bass_db = BASS_MAX_LIMIT;
            end else begin
                next_bass_db = bass_raw_db;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tone_mode_eff    <= TONE_FLAT;
            attenuation_db   <= 6'h00;
            full_attenuation <= 1'b0;
            bass_gain_db     <= 5'h00;
            treble_gain_db   <= 3'h0;
            dac_power_on     <= 1'b0;
            adc_power_on     <= 1'b0;
        end else begin
            tone_mode_eff    <= next_tone_eff;
            attenuation_db   <= next_atten_db;
            full_attenuation <= (playback_attenuation > VOLUME_MAX_STEP);
            bass_gain_db     <= next_bass_db;
            treble_gain_db   <= next_treble_db;
            dac_power_on     <= converter_power_sel[0];
            adc_power_on     <= converter_power_sel[1];
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_addr_data_open;
        byte_event && !hold_mode && addr_match && (xfer_type == TYPE_DATA)
            |=> (session == SESSION_DATA) ##1 iface_selected;
    endproperty
    a_addr_data_open: assert property (p_addr_data_open) else $error("data group not opened");

    property p_addr_foreign;
        byte_event && !hold_mode && !addr_match |=> (session == SESSION_DESELECTED) && !iface_selected;
    endproperty
    a_addr_foreign: assert property (p_addr_foreign) else $error("foreign address kept selection");

    property p_data_keeps_session;
        byte_event && hold_mode |=> $stable(session);
    endproperty
    a_data_keeps_session: assert property (p_data_keeps_session) else $error("data byte moved session");

    property p_volume_load;
        data_write && (reg_sel == SEL_VOLUME) |=> playback_attenuation == $past(hold_byte[5:0]);
    endproperty
    a_volume_load: assert property (p_volume_load) else $error("volume not loaded");

    property p_no_event_no_write;
        !byte_event |=> $stable(playback_attenuation) && $stable(converter_power_sel) && $stable(audio_format);
    endproperty
    a_no_event_no_write: assert property (p_no_event_no_write) else $error("write without byte");

    property p_unused_blocks;
        (session == SESSION_UNUSED) && byte_event && hold_mode |=> $stable({playback_attenuation,
            bass_level, high_shelf_level, converter_power_sel, audio_format});
    endproperty
    a_unused_blocks: assert property (p_unused_blocks) else $error("write in unused group");

    property p_status_load;
        status_write && (reg_sel == SEL_SETUP)
            |=> {master_clock_ratio, audio_format, offset_removal_en} == $past(hold_byte[5:0]);
    endproperty
    a_status_load: assert property (p_status_load) else $error("status not loaded");

    property p_flat_tone;
        (tone_mode == 2'h0) && $stable(tone_mode) |=> (bass_gain_db == 5'h00) && (treble_gain_db == 3'h0);
    endproperty
    a_flat_tone: assert property (p_flat_tone) else $error("flat mode boosts");

    property p_volume_floor;
        (playback_attenuation == VOLUME_MAX_STEP) |=> (attenuation_db == 6'h3C) && !full_attenuation;
    endproperty
    a_volume_floor: assert property (p_volume_floor) else $error("volume step 60 wrong");

    property p_link_count;
        @(posedge ctl_shift_clock) disable iff (reset)
            (bit_count == BIT_COUNT_FULL) |=> (bit_count == BIT_COUNT_ONE) && $changed(hold_toggle) == 1'b0;
    endproperty
    a_link_count: assert property (p_link_count) else $error("byte framing slipped");

    c_addr_accept: cover property (byte_event && !hold_mode && addr_match);
    c_volume_write: cover property (data_write && (reg_sel == SEL_VOLUME));
    c_status_write: cover property (status_write);
    c_deselect: cover property ((session == SESSION_DATA) ##[1:200] (session == SESSION_DESELECTED));

endmodule : ccp_control_port

/* verilog/ccp_sync2.sv */
// Module: two flip-flop level synchroniser
`timescale 1ns/1ps
module ccp_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock,    // destination clock
    input  wire logic             reset,    // async reset, active high
    input  wire logic [WIDTH-1:0] async_in, // level from another domain
    output logic      [WIDTH-1:0] sync_out  // synchronised level
);
    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second stage
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule : ccp_sync2
